// ### design/down_timer_pkg.sv
// constants, field layout and carrier types of the reloadable down timer
package down_timer_pkg;
   // clock and noise rejector timing
   localparam int CLK_HZ        = 100_000_000;
   localparam int NR_SAMPLE_HZ  = 256;
   localparam int NR_TICK_HZ    = NR_SAMPLE_HZ * 4;
   localparam int NR_TICK_CYC   = CLK_HZ / NR_TICK_HZ;
   localparam int REJECT_US     = 2000;
   localparam int ACCEPT_US     = 6000;
   localparam int NR_STABLE     =
      (((REJECT_US + ACCEPT_US) / 2) * NR_TICK_HZ) / 1_000_000;

   // register indices, byte address is four times the index
   localparam logic [7:0] IDX_IRQ_FLAG = 8'hc0;
   localparam logic [7:0] IDX_IRQ_MASK = 8'hc8;
   localparam logic [7:0] IDX_CONTROL  = 8'he9;
   localparam logic [7:0] IDX_CLK_SEL  = 8'hea;
   localparam logic [7:0] IDX_CNT_LO   = 8'heb;
   localparam logic [7:0] IDX_CNT_HI   = 8'hec;
   localparam logic [7:0] IDX_RLD_LO   = 8'hed;
   localparam logic [7:0] IDX_RLD_HI   = 8'hee;

   // field positions
   localparam int CTL_STROBE_BIT = 0;
   localparam int CTL_RUN_BIT    = 1;
   localparam int CTL_OUTSEL_BIT = 3;
   localparam int SEL_SRC_LSB    = 0;
   localparam int SEL_DIV_LSB    = 2;
   localparam int MSK_TIMER_BIT  = 0;
   localparam int MSK_SERIAL_BIT = 1;
   localparam int MSK_CONV_BIT   = 2;

   // reset values
   localparam logic [3:0] CLK_SEL_RST = 4'h0;
   localparam logic [2:0] MASK_RST    = 3'h0;

   // counted clock sources
   typedef enum logic [1:0] {
      SRC_KEY_NR = 2'h0,
      SRC_KEY    = 2'h1,
      SRC_SLOW   = 2'h2,
      SRC_FAST   = 2'h3
   } src_t;

   // wishbone request and answer
   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [9:0]  adr;
      logic [3:0]  sel;
      logic [31:0] dat;
   } wb_req_t;

   typedef struct packed {
      logic        ack;
      logic [31:0] dat;
   } wb_rsp_t;
endpackage

// ### design/reloadable_down_timer.sv
// reloadable 8-bit down timer with wishbone register slave
//
// The implementer's own choice: the Wishbone interface to the registers.
`timescale 1ns/1ns

// Behaviour
// - two-bit source field picks counted clock
// - pre-divider divides by 256, 32, 4, 1
// - key counts falling edge, oscillators rising
// - key noise rejector drops 2ms, keeps 6ms
// - reload from reload register at zero
// - reload strobe copies reload, reads zero
// - run bit enables, clear halts counting
// - strobe while running resumes, stopped holds
// - count readable as low and high nibble
// - flag set on reaching zero regardless mask
// - request only when timer mask bit set
// - flag clears after read, unused bits zero
// - overflow toggles together with reload
// - select bit routes overflow to pin
// - reload value written and read as nibbles
// - reset clears control, select and mask
// - reload zero gives 256 counts
// - pin frequency is input over twice reload
module reloadable_down_timer
   import down_timer_pkg::*;
#(
   parameter int NR_TICK_CYCLES = NR_TICK_CYC
) (
   // clock and reset
   input  wire logic    ref_clk,
   input  wire logic    srst,
   // register bus
   input  wire wb_req_t wb_req,
   output wb_rsp_t      wb_rsp,
   // count clock inputs
   input  wire logic    key_count_input,
   input  wire logic    slow_osc_clock,
   input  wire logic    fast_osc_clock,
   // output port static level
   input  wire logic    port_static_level,
   // outputs
   output logic         shared_output_pin,
   output logic         overflow_toggle,
   output logic         timer_irq_pending,
   output logic         timer_irq_req,
   output logic         serial_irq_enable,
   output logic         converter_irq_enable
);

   // decode of a register index from the byte address
   function automatic logic [7:0] reg_idx(input logic [9:0] adr);
      reg_idx = adr[9:2];
   endfunction

   // divider mask per pre-divider code
   function automatic logic [7:0] div_mask(input logic [1:0] code);
      case (code)
         2'h0:    div_mask = 8'hff;
         2'h1:    div_mask = 8'h1f;
         2'h2:    div_mask = 8'h03;
         default: div_mask = 8'h00;
      endcase
   endfunction

   logic [3:0]  clk_sel_q;
   logic        run_q;
   logic        out_sel_q;
   logic [2:0]  mask_q;
   logic [7:0]  reload_q;
   logic [7:0]  count_q;
   logic        toggle_q;
   logic        flag_q;
   logic        ack_q;
   logic [31:0] rdat_q;
   logic        irq_q;
   logic        pin_q;

   logic        req;
   logic        wr;
   logic        rd;
   logic [7:0]  idx;
   logic        strobe;
   logic        wrap;

   // bus decode: effects take place on the acknowledged edge
   assign req    = wb_req.cyc & wb_req.stb;
   assign idx    = reg_idx(wb_req.adr);
   assign wr     = req & ack_q & wb_req.we & wb_req.sel[0];
   assign rd     = req & ack_q & ~wb_req.we;
   assign strobe = wr & (idx == IDX_CONTROL)
                 & wb_req.dat[CTL_STROBE_BIT];

   // input synchronisers, first stage read only by second
   logic [2:0] sync1_q;
   logic [2:0] sync2_q;
   always_ff @(posedge ref_clk) begin
      sync1_q <= {fast_osc_clock, slow_osc_clock, key_count_input};
      sync2_q <= sync1_q;
   end

   // noise rejector tick at four times the sampling rate
   logic [16:0] nr_div_q;
   logic        nr_tick;
   assign nr_tick = (nr_div_q == 17'(NR_TICK_CYCLES - 1));
   always_ff @(posedge ref_clk) begin
      if (srst || nr_tick)
         nr_div_q <= 17'h0;
      else
         nr_div_q <= nr_div_q + 17'h1;
   end

   // key level accepted after one sampling period of stability
   logic [2:0] nr_cnt_q;
   logic       key_nr_q;
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         nr_cnt_q <= 3'h0;
         key_nr_q <= 1'b1;
      end else if (sync2_q[0] == key_nr_q) begin
         nr_cnt_q <= 3'h0; // short pulse discarded
      end else if (nr_tick) begin
         if (nr_cnt_q == 3'(NR_STABLE - 1)) begin
            key_nr_q <= sync2_q[0];
            nr_cnt_q <= 3'h0;
         end else begin
            nr_cnt_q <= nr_cnt_q + 3'h1;
         end
      end
   end

   // source select and active edge detection
   logic src_lvl;
   logic src_prev_q;
   logic src_edge;
   always_comb begin
      case (src_t'(clk_sel_q[SEL_SRC_LSB +: 2]))
         SRC_KEY_NR: src_lvl = key_nr_q;
         SRC_KEY:    src_lvl = sync2_q[0];
         SRC_SLOW:   src_lvl = sync2_q[1];
         default:    src_lvl = sync2_q[2];
      endcase
   end
   always_ff @(posedge ref_clk) begin
      if (srst)
         src_prev_q <= 1'b1;
      else
         src_prev_q <= src_lvl;
   end
   // key sources count falling edges, oscillators rising
   assign src_edge = clk_sel_q[SEL_SRC_LSB + 1]
                   ? (src_lvl & ~src_prev_q)
                   : (~src_lvl & src_prev_q);

   // pre-divider
   logic [7:0] pre_q;
   logic       cnt_tick;
   logic [7:0] dmask;
   assign dmask    = div_mask(clk_sel_q[SEL_DIV_LSB +: 2]);
   assign cnt_tick = src_edge & ((pre_q & dmask) == dmask);
   always_ff @(posedge ref_clk) begin
      if (srst || strobe)
         pre_q <= 8'h0;
      else if (run_q && src_edge)
         pre_q <= pre_q + 8'h1;
   end

   // wrap happens as the count leaves one towards zero
   assign wrap = run_q & cnt_tick & ~strobe & (count_q == 8'h01);

   // down counter with automatic reload
   always_ff @(posedge ref_clk) begin
      if (strobe)
         count_q <= reload_q;
      else if (wrap)
         count_q <= reload_q;
      else if (run_q && cnt_tick)
         count_q <= count_q - 8'h1;
   end

   // overflow toggle, flips with every reload from wrap
   always_ff @(posedge ref_clk) begin
      if (srst)
         toggle_q <= 1'b0;
      else if (wrap)
         toggle_q <= ~toggle_q;
   end

   // interrupt factor flag, a new event wins over the read clear
   always_ff @(posedge ref_clk) begin
      if (srst)
         flag_q <= 1'b0;
      else if (wrap)
         flag_q <= 1'b1;
      else if (rd && idx == IDX_IRQ_FLAG)
         flag_q <= 1'b0;
   end

   // control and configuration registers
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         run_q     <= 1'b0;
         out_sel_q <= 1'b0;
         clk_sel_q <= CLK_SEL_RST;
         mask_q    <= MASK_RST;
      end else if (wr) begin
         case (idx)
            IDX_CONTROL: begin
               run_q     <= wb_req.dat[CTL_RUN_BIT];
               out_sel_q <= wb_req.dat[CTL_OUTSEL_BIT];
            end
            IDX_CLK_SEL:  clk_sel_q <= wb_req.dat[3:0];
            IDX_IRQ_MASK: mask_q    <= wb_req.dat[2:0];
            default: ;
         endcase
      end
   end

   // reload register nibbles, left undefined by reset
   always_ff @(posedge ref_clk) begin
      if (wr && idx == IDX_RLD_LO)
         reload_q[3:0] <= wb_req.dat[3:0];
      if (wr && idx == IDX_RLD_HI)
         reload_q[7:4] <= wb_req.dat[3:0];
   end

   // read data, captured when the request arrives
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         rdat_q <= 32'h0;
      end else if (req && !ack_q) begin
         case (idx)
            IDX_IRQ_FLAG: rdat_q <= {31'h0, flag_q};
            IDX_IRQ_MASK: rdat_q <= {29'h0, mask_q};
            IDX_CONTROL:  rdat_q <= {28'h0, out_sel_q, 1'b0,
                                     run_q, 1'b0};
            IDX_CLK_SEL:  rdat_q <= {28'h0, clk_sel_q};
            IDX_CNT_LO:   rdat_q <= {28'h0, count_q[3:0]};
            IDX_CNT_HI:   rdat_q <= {28'h0, count_q[7:4]};
            IDX_RLD_LO:   rdat_q <= {28'h0, reload_q[3:0]};
            IDX_RLD_HI:   rdat_q <= {28'h0, reload_q[7:4]};
            default:      rdat_q <= 32'h0;
         endcase
      end
   end

   // acknowledge one cycle after the request, every address
   always_ff @(posedge ref_clk) begin
      if (srst)
         ack_q <= 1'b0;
      else
         ack_q <= req & ~ack_q;
   end

   // registered interrupt request and pin drive
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         irq_q <= 1'b0;
         pin_q <= 1'b0;
      end else begin
         irq_q <= flag_q & mask_q[MSK_TIMER_BIT];
         pin_q <= out_sel_q ? toggle_q : port_static_level;
      end
   end

   // outputs
   assign wb_rsp.ack           = ack_q;
   assign wb_rsp.dat           = rdat_q;
   assign shared_output_pin    = pin_q;
   assign overflow_toggle      = toggle_q;
   assign timer_irq_pending    = flag_q;
   assign timer_irq_req        = irq_q;
   assign serial_irq_enable    = mask_q[MSK_SERIAL_BIT];
   assign converter_irq_enable = mask_q[MSK_CONV_BIT];

   // checks
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (srst);

   reload_on_wrap_a: assert property (
      wrap |=> count_q == $past(reload_q))
      else $error("count not reloaded at wrap");

   strobe_load_a: assert property (
      strobe ##1 !strobe && !run_q |=> count_q == $past(reload_q, 2))
      else $error("stopped strobe did not load and hold");

   stop_hold_a: assert property (
      !run_q && !strobe |=> $stable(count_q))
      else $error("count moved while stopped");

   ctl_read_zero_a: assert property (
      ack_q && !wb_req.we && idx == IDX_CONTROL |-> !rdat_q[0])
      else $error("reload strobe read nonzero");

   flag_set_a: assert property (
      wrap |=> flag_q)
      else $error("flag not set at wrap");

   flag_clear_a: assert property (
      rd && idx == IDX_IRQ_FLAG && !wrap |=> !flag_q)
      else $error("flag not cleared by read");

   irq_gate_a: assert property (
      ##1 timer_irq_req == $past(flag_q && mask_q[MSK_TIMER_BIT]))
      else $error("irq request wrong");

   toggle_wrap_a: assert property (
      toggle_q != $past(toggle_q) |-> $past(wrap))
      else $error("toggle without wrap");

   pin_route_a: assert property (
      out_sel_q |=> shared_output_pin == $past(toggle_q))
      else $error("pin not routed from overflow");

   ack_single_a: assert property (
      ack_q |=> !ack_q)
      else $error("ack longer than one cycle");

   ack_answer_a: assert property (
      req && !ack_q |=> ack_q)
      else $error("request not answered next cycle");

   count_step_a: assert property (
      run_q && cnt_tick && !strobe && !wrap
         |=> count_q == $past(count_q) - 8'h01)
      else $error("count did not step down by one");

   run_strobe_a: assert property (
      strobe && wb_req.dat[CTL_RUN_BIT]
         |=> run_q && count_q == $past(reload_q))
      else $error("running strobe did not reload");

   mask_gate_a: assert property (
      !mask_q[MSK_TIMER_BIT] |=> !timer_irq_req)
      else $error("request raised while masked");

   read_upper_zero_a: assert property (
      ack_q && !wb_req.we |-> rdat_q[31:4] == 28'h0)
      else $error("unused read bits nonzero");

   wrap_cov_c:   cover property (wrap ##[1:300] wrap);
   reload_zero_c: cover property (wrap && reload_q == 8'h00);
   strobe_cov_c: cover property (strobe ##1 run_q);
   irq_cov_c:    cover property (timer_irq_req ##1 !flag_q);
endmodule

// ### tb/reloadable_down_timer_test.sv
// self-checking testbench of the reloadable down timer
`timescale 1ns/1ns
module reloadable_down_timer_test;
   import down_timer_pkg::*;
   typedef struct packed {
      logic       we;
      logic [7:0] idx;
      logic [3:0] wd;
      logic [3:0] ex;
   } row_t;
   // design signals and bench state
   logic       ref_clk, srst, key, slow, fast, lvl;
   logic       pin, tog, flag, irq, sen, cen, exp_tog;
   logic [3:0] q;
   wb_req_t    req;
   wb_rsp_t    rsp;
   int         num_errors, tests_run;
   // register rows: write flag, index, write data, expected read data
   row_t rows[19] = '{
      '{1'b0,8'hea,4'h0,4'h0}, '{1'b0,8'he9,4'h0,4'h0},
      '{1'b0,8'hc8,4'h0,4'h0}, '{1'b0,8'hc0,4'h0,4'h0},
      '{1'b1,8'hed,4'h5,4'h0}, '{1'b1,8'hee,4'ha,4'h0},
      '{1'b0,8'hed,4'h0,4'h5}, '{1'b0,8'hee,4'h0,4'ha},
      '{1'b1,8'he9,4'h1,4'h0}, '{1'b0,8'he9,4'h0,4'h0},
      '{1'b0,8'heb,4'h0,4'h5}, '{1'b0,8'hec,4'h0,4'ha},
      '{1'b1,8'heb,4'h3,4'h0}, '{1'b0,8'heb,4'h0,4'h5},
      '{1'b0,8'h20,4'h0,4'h0}, '{1'b1,8'hc8,4'hf,4'h0},
      '{1'b0,8'hc8,4'h0,4'h7}, '{1'b1,8'hea,4'hf,4'h0},
      '{1'b0,8'hea,4'h0,4'hf}};
   // counting cases: source, divider code, reload, edges per wrap
   int cs[7][4] = '{'{3,3,2,2}, '{2,2,1,4}, '{3,1,1,32},
      '{3,0,1,256}, '{1,3,3,3}, '{0,3,1,1}, '{3,3,0,256}};

   reloadable_down_timer #(.NR_TICK_CYCLES(10)) u_dut (
      .ref_clk              (ref_clk),
      .srst                 (srst),
      .wb_req               (req),
      .wb_rsp               (rsp),
      .key_count_input      (key),
      .slow_osc_clock       (slow),
      .fast_osc_clock       (fast),
      .port_static_level    (lvl),
      .shared_output_pin    (pin),
      .overflow_toggle      (tog),
      .timer_irq_pending    (flag),
      .timer_irq_req        (irq),
      .serial_irq_enable    (sen),
      .converter_irq_enable (cen));

   // 100 MHz clock
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   task automatic check(input logic [7:0] seen, exp, input string what);
      tests_run++;
      if (seen !== exp) begin
         num_errors++;
         $display("BAD %0t %s: got %h want %h", $time, what, seen, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
   endtask

   // one classic wishbone cycle, held until ack is sampled
   task automatic bus(input logic we, input logic [7:0] idx,
                      input logic [3:0] wd, output logic [3:0] rd);
      int n;
      n = 0;
      req <= '{1'b1, 1'b1, we, {idx, 2'b00}, 4'h1, {28'h0, wd}};
      @(posedge ref_clk);
      while (rsp.ack !== 1'b1 && n < 20) begin
         @(posedge ref_clk);
         n++;
      end
      if (n == 20)
         check(8'h0, 8'h1, "bus ack missing");
      rd = rsp.dat[3:0];
      req <= '0;
      @(posedge ref_clk);
   endtask

   // n full periods of the chosen count clock, oscillators end low, the key ends high
   task automatic edges(input int s, input int n, input int half);
      repeat (2 * n) begin
         if (s < 2)
            key <= ~key;
         else if (s == 2)
            slow <= ~slow;
         else
            fast <= ~fast;
         tick(half);
      end
   endtask

   // stop, load reload, select clock, strobe, run, clear flag
   task automatic start(input int s, d, r);
      bus(1'b1, 8'he9, 4'h0, q);
      bus(1'b1, 8'hed, r[3:0], q);
      bus(1'b1, 8'hee, r[7:4], q);
      bus(1'b1, 8'hea, {d[1:0], s[1:0]}, q);
      bus(1'b1, 8'he9, 4'h1, q);
      bus(1'b0, 8'heb, 4'h0, q);
      check(q, r[3:0], "count after strobe");
      bus(1'b1, 8'he9, 4'h2, q);
      bus(1'b0, 8'hc0, 4'h0, q);
   endtask

   task automatic test_done;
      $display("comparisons %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // watchdog
   initial begin
      tick(60000);
      num_errors++;
      test_done();
   end

   // main sequence
   initial begin
      srst = 1'b1;
      key = 1'b1;
      slow = 1'b0;
      fast = 1'b0;
      lvl = 1'b0;
      req = '0;
      exp_tog = 1'b0;
      tick(12);
      srst <= 1'b0;
      tick(1);
      check({pin, tog, flag, irq, sen, cen}, 8'h0, "reset outputs");
      foreach (rows[i]) begin
         bus(rows[i].we, rows[i].idx, rows[i].wd, q);
         if (!rows[i].we)
            check(q, rows[i].ex, "register read");
      end
      check({sen, cen}, 8'h3, "mask outputs");
      bus(1'b1, 8'hc8, 4'h0, q);
      $display("register table done");
      foreach (cs[i]) begin
         start(cs[i][0], cs[i][1], cs[i][2]);
         edges(cs[i][0], cs[i][3] - 1, cs[i][0] == 0 ? 80 : 4);
         tick(8);
         check(tog, exp_tog, "early toggle");
         edges(cs[i][0], 1, cs[i][0] == 0 ? 80 : 4);
         tick(8);
         exp_tog = ~exp_tog;
         check(tog, exp_tog, "toggle at wrap");
         bus(1'b0, 8'hc0, 4'h0, q);
         check(q, 8'h1, "flag at wrap");
         bus(1'b0, 8'heb, 4'h0, q);
         check(q, cs[i][2] & 15, "count reloaded");
         $display("count case %0d done", i);
      end
      // key counts on its fall only, strobe while running reloads
      start(1, 3, 3);
      key <= 1'b0;
      tick(8);
      bus(1'b0, 8'heb, 4'h0, q);
      check(q, 8'h2, "key fall counted");
      key <= 1'b1;
      tick(8);
      bus(1'b0, 8'heb, 4'h0, q);
      check(q, 8'h2, "key rise ignored");
      bus(1'b1, 8'he9, 4'h3, q);
      bus(1'b0, 8'heb, 4'h0, q);
      check(q, 8'h3, "strobe while running");
      bus(1'b0, 8'he9, 4'h0, q);
      check(q, 8'h2, "run kept after strobe");
      // oscillator counts on its rise only
      start(3, 3, 3);
      fast <= 1'b1;
      tick(8);
      bus(1'b0, 8'heb, 4'h0, q);
      check(q, 8'h2, "fast rise counted");
      fast <= 1'b0;
      tick(8);
      bus(1'b0, 8'heb, 4'h0, q);
      check(q, 8'h2, "fast fall ignored");
      $display("edge polarity test done");
      // masked flag, then unmasked request and read clear
      start(3, 3, 1);
      edges(3, 1, 4);
      tick(8);
      exp_tog = ~exp_tog;
      check({flag, irq}, 8'h2, "masked flag");
      bus(1'b1, 8'hc8, 4'h1, q);
      tick(3);
      check(irq, 1'b1, "request unmasked");
      bus(1'b0, 8'hc0, 4'h0, q);
      check(q, 8'h1, "flag read");
      tick(2);
      check({flag, irq}, 8'h0, "flag cleared");
      // routing to the pin with port data low, then static level
      lvl <= 1'b0;
      bus(1'b1, 8'he9, 4'ha, q);
      tick(3);
      check(pin, exp_tog, "pin carries toggle");
      edges(3, 1, 4);
      tick(8);
      exp_tog = ~exp_tog;
      check(pin, exp_tog, "pin follows toggle");
      lvl <= 1'b1;
      bus(1'b1, 8'he9, 4'h0, q);
      tick(3);
      check(pin, 1'b1, "pin static");
      edges(3, 3, 4);
      tick(8);
      check(tog, exp_tog, "stopped holds");
      $display("irq and pin tests done");
      // noise rejector drops a short low glitch
      start(0, 3, 1);
      key <= 1'b0;
      tick(15);
      key <= 1'b1;
      tick(100);
      check(tog, exp_tog, "glitch rejected");
      edges(0, 1, 80);
      tick(8);
      exp_tog = ~exp_tog;
      check(tog, exp_tog, "long pulse counted");
      $display("noise rejector test done");
      // second reset in mid-run
      srst <= 1'b1;
      tick(2);
      srst <= 1'b0;
      tick(1);
      check({pin, tog, flag, irq, sen, cen}, 8'h0, "mid-run reset");
      bus(1'b0, 8'hea, 4'h0, q);
      check(q, 8'h0, "select after reset");
      $display("reset test done");
      test_done();
   end
endmodule
